//--- bench/ubg_baud_gen_tb.sv
`timescale 1ns/100ps
module ubg_baud_gen_tb;
   logic clk, rst_n, hsel, hwrite, hready, hresp, t1_pin, t2_pin;
   logic [7:0] haddr;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] hwdata, hrdata, tx_per, rx_per, tx_smp, rx_smp, tx_n, rx_n;
   logic [2:0] div_q;
   logic tx_bit, tx_smpl, rx_bit, rx_smpl;
   int err_total, compares, cycles;

   // ------------------------------------------------------------
   // Clock, pin stimulus and timeout
   // ------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // Counter pin toggles every 4 cycles, period 8
   always @(posedge clk) begin
      div_q <= div_q + 3'h1;
      t1_pin <= div_q[2];
      cycles++;
      if (cycles == 40000) begin
         err_total++;
         conclude();
      end
   end

   // ------------------------------------------------------------
   // Design and shifter models
   // ------------------------------------------------------------
   ubg_baud_gen DUT (.core_clk_in(clk), .reset_n_in(rst_n), .hsel_in(hsel), .haddr_in(haddr),
      .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hready_in(hready),
      .hwdata_in(hwdata), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
      .t1_count_pin_in(t1_pin), .t2_ext_pin_in(t2_pin), .tx_bit_tick_out(tx_bit),
      .tx_sample_tick_out(tx_smpl), .rx_bit_tick_out(rx_bit), .rx_sample_tick_out(rx_smpl));
   ubg_shift_model tx_model (.core_clk_in(clk), .reset_n_in(rst_n), .bit_tick_in(tx_bit),
      .sample_tick_in(tx_smpl), .period_out(tx_per), .samples_out(tx_smp), .nbits_out(tx_n));
   ubg_shift_model rx_model (.core_clk_in(clk), .reset_n_in(rst_n), .bit_tick_in(rx_bit),
      .sample_tick_in(rx_smpl), .period_out(rx_per), .samples_out(rx_smp), .nbits_out(rx_n));

   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic conclude();
      if (err_total == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Single AHB-Lite transfer: address phase, then data phase
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'b10;
      hwrite <= wr;
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'b00;
      hsel <= 1'b0;
      hwdata <= wd;
      do @(posedge clk); while (hready !== 1'b1);
      rd = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      xfer(1'b1, a, d, x);
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] x;
      xfer(1'b0, a, 32'h0, x);
      check(x & m, e);
   endtask

   // Lets both directions run three more bit ticks on the new setting
   task automatic settle();
      logic [31:0] t0, r0;
      t0 = tx_n;
      r0 = rx_n;
      while (tx_n < t0 + 32'h3 || rx_n < r0 + 32'h3) @(posedge clk);
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      rst_n = 1'b0;
      {hsel, hwrite, haddr, htrans, hwdata, t2_pin} = {1'b0, 1'b0, 8'h00, 2'b00, 32'h0, 1'b1};
      {hsize, div_q, t1_pin} = {3'b010, 3'h0, 1'b0};
      err_total = 0;
      compares = 0;
      cycles = 0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      // Reset values, unmapped place written and read back as zero
      wr(8'h18, 32'hffffffff);
      for (int i = 0; i < 7; i++) rchk(8'(4 * i), 32'hffffffff, 32'h0);
      // Timer 2 generator for both directions, reload fffe: 64 cycles a bit
      wr(8'h0c, 32'h0000fffe);
      wr(8'h10, 32'h0000fffe);
      wr(8'h04, 32'h0000003c);
      settle();
      check(tx_per, 32'h40);
      check(rx_per, 32'h40);
      check(tx_smp, 32'h10);
      // External event sets its flag, overflow flag stays clear
      @(posedge clk) t2_pin <= 1'b0;
      repeat (10) @(posedge clk);
      t2_pin <= 1'b1;
      repeat (10) @(posedge clk);
      rchk(8'h04, 32'h000000ff, 32'h0000007c);
      // Receive moves to timer 1 in 8-bit reload, reload byte fd
      wr(8'h08, 32'h0000fdfd);
      wr(8'h00, 32'h00000021);
      wr(8'h04, 32'h00000014);
      settle();
      check(tx_per, 32'h40);
      check(rx_per, 32'h60);
      check(rx_smp, 32'h10);
      rchk(8'h08, 32'h0000ff00, 32'h0000fd00);
      wr(8'h14, 32'h00000001);
      settle();
      check(rx_per, 32'h30);
      check(rx_smp, 32'h10);
      // Timer 1 counting pin edges, reload ff, doubled: 8 x 16 cycles
      wr(8'h08, 32'h0000ffff);
      wr(8'h00, 32'h00000061);
      settle();
      check(rx_per, 32'h80);
      // Timer 2 plain autoreload from fff0 sets its overflow flag
      wr(8'h0c, 32'h0000fff0);
      wr(8'h04, 32'h00000004);
      repeat (100) @(posedge clk);
      rchk(8'h04, 32'h00000080, 32'h00000080);
      rchk(8'h10, 32'h0000fff0, 32'h0000fff0);
      check({31'h0, hresp}, 32'h0);
      conclude();
   end
endmodule

//--- bench/ubg_shift_model.sv
`timescale 1ns/100ps
module ubg_shift_model (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic reset_n_in,
   // Ticks from the generator
   input wire logic bit_tick_in,
   input wire logic sample_tick_in,
   // Measured bit timing
   output logic [31:0] period_out,
   output logic [31:0] samples_out,
   output logic [31:0] nbits_out
);
   logic [31:0] cyc_q;
   logic [31:0] samp_q;

   // Shifter side: times each bit and counts its sample ticks
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         cyc_q <= 32'h0;
         samp_q <= 32'h0;
         period_out <= 32'h0;
         samples_out <= 32'h0;
         nbits_out <= 32'h0;
      end else if (bit_tick_in) begin
         period_out <= cyc_q + 32'h1;
         samples_out <= samp_q + {31'h0, sample_tick_in};
         nbits_out <= nbits_out + 32'h1;
         cyc_q <= 32'h0;
         samp_q <= 32'h0;
      end else begin
         cyc_q <= cyc_q + 32'h1;
         samp_q <= samp_q + {31'h0, sample_tick_in};
      end
   end
endmodule

//--- src/ubg_baud_gen.sv
// Added by the designer: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/100ps
// What this block does
// RULE1: Variable-rate serial bit clocks come from timer overflows, per direction.
// RULE2: Timer 1 path divides overflows by 32, or 16 with double_rate_bit.
// RULE3: Timer 1 works timer or counter, any running mode; reload gives clk/(256-TH).
// RULE4: Timer 2 path needs sixteen overflows per bit.
// RULE5: Timer 2 as generator advances once every two core cycles.
// RULE6: Select bits in timer2_control_reg put timer 2 in generator use per direction.
// RULE7: Timer 2 generator rate is clock / (32 x (65536 - reload pair)).
// RULE8: Generator use never sets t2_overflow_flag; external flag still works.
// RULE9: Timer 2 rollover outside capture use reloads the count from the reload pair.
// RULE10: 8-bit reload mode reloads low byte from high byte, high unchanged.
// RULE11: A direction without its timer 2 select takes timer 1 overflows.
module ubg_baud_gen (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic reset_n_in,
   // AHB-Lite slave
   input wire logic hsel_in,
   input wire logic [7:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic [2:0] hsize_in,
   input wire logic hready_in,
   input wire logic [31:0] hwdata_in,
   output logic [31:0] hrdata_out,
   output logic hreadyout_out,
   output logic hresp_out,
   // Timer pins
   input wire logic t1_count_pin_in,
   input wire logic t2_ext_pin_in,
   // Bit clocks to the shifters
   output logic tx_bit_tick_out,
   output logic tx_sample_tick_out,
   output logic rx_bit_tick_out,
   output logic rx_sample_tick_out
);

   // ----------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------
   logic [7:0] timer_mode_reg_q;
   logic [7:0] timer2_control_reg_q;
   logic [7:0] timer2_control_reg_d;
   logic [7:0] serial_cfg_q;
   logic [15:0] t2_reload_q; // t2_reload_high : t2_reload_low
   logic [15:0] t2_reload_d;
   logic [15:0] t2_count_q;
   logic [15:0] t2_count_d;
   logic t2_ovf_q;
   logic t2_phase_q;
   logic t1_half_q;
   logic dph_wr_q;
   logic [7:0] dph_addr_q;
   logic [31:0] hrdata_q;
   logic hready_q;
   logic [1:0] sync1_q;
   logic [1:0] sync2_q;
   logic [1:0] sync3_q;
   logic [1:0] pin_lvl_q;
   logic [15:0] t1_count;
   logic t1_ovf;
   ubg_pkg::ubg_sel_t sel;
   ubg_pkg::ubg_tick_t tx_tick;
   ubg_pkg::ubg_tick_t rx_tick;

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction

   // Address phase acceptance and data phase strobes
   wire addr_take = hsel_in & htrans_in[1] & hready_in & (hsize_in == 3'b010);
   wire wr_mode = dph_wr_q & hit(dph_addr_q, ubg_pkg::OFS_TIMER_MODE);
   wire wr_t2ctl = dph_wr_q & hit(dph_addr_q, ubg_pkg::OFS_T2_CONTROL);
   wire wr_t1cnt = dph_wr_q & hit(dph_addr_q, ubg_pkg::OFS_T1_COUNT);
   wire wr_t2rld = dph_wr_q & hit(dph_addr_q, ubg_pkg::OFS_T2_RELOAD);
   wire wr_t2cnt = dph_wr_q & hit(dph_addr_q, ubg_pkg::OFS_T2_COUNT);
   wire wr_ser = dph_wr_q & hit(dph_addr_q, ubg_pkg::OFS_SERIAL_CFG);

   // Read mux, unmapped addresses read zero
   wire [31:0] rd_mux =
      hit(haddr_in, ubg_pkg::OFS_TIMER_MODE) ? {24'h000000, timer_mode_reg_q} :
      hit(haddr_in, ubg_pkg::OFS_T2_CONTROL) ? {24'h000000, timer2_control_reg_q} :
      hit(haddr_in, ubg_pkg::OFS_T1_COUNT) ? {16'h0000, t1_count} :
      hit(haddr_in, ubg_pkg::OFS_T2_RELOAD) ? {16'h0000, t2_reload_q} :
      hit(haddr_in, ubg_pkg::OFS_T2_COUNT) ? {16'h0000, t2_count_q} :
      hit(haddr_in, ubg_pkg::OFS_SERIAL_CFG) ? {24'h000000, serial_cfg_q} : 32'h00000000;

   // Address phase capture and registered read data
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         dph_wr_q <= 1'b0;
         dph_addr_q <= 8'h00;
         hrdata_q <= 32'h00000000;
         hready_q <= 1'b0;
      end else begin
         hready_q <= 1'b1;
         dph_wr_q <= addr_take & hwrite_in;
         dph_addr_q <= haddr_in;
         if (addr_take & ~hwrite_in) begin
            hrdata_q <= rd_mux;
         end
      end
   end

   assign hrdata_out = hrdata_q;
   assign hreadyout_out = hready_q;

   // Response is always OKAY
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         hresp_out <= 1'b0;
      end else begin
         hresp_out <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Pin synchronisers, a level counts once stages two and three agree
   // ----------------------------------------------------------------
   wire [1:0] pin_agree = ~(sync2_q ^ sync3_q);
   wire [1:0] pin_fall = pin_lvl_q & ~sync2_q & pin_agree;

   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         sync1_q <= 2'b11;
         sync2_q <= 2'b11;
         sync3_q <= 2'b11;
         pin_lvl_q <= 2'b11;
      end else begin
         sync1_q <= {t2_ext_pin_in, t1_count_pin_in};
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
         pin_lvl_q <= (pin_agree & sync2_q) | (~pin_agree & pin_lvl_q);
      end
   end

   // ----------------------------------------------------------------
   // Configuration fields
   // ----------------------------------------------------------------
   assign sel.double_rate = serial_cfg_q[ubg_pkg::DOUBLE_RATE_BIT];
   assign sel.rx_t2 = timer2_control_reg_q[ubg_pkg::RX_CLOCK_FROM_T2_BIT];
   assign sel.tx_t2 = timer2_control_reg_q[ubg_pkg::TX_CLOCK_FROM_T2_BIT];
   wire t2_brg = sel.rx_t2 | sel.tx_t2; // RULE6
   wire t2_run = timer2_control_reg_q[ubg_pkg::T2_RUN_BIT];
   wire t2_cap = timer2_control_reg_q[ubg_pkg::T2_CAPTURE_BIT];
   wire t2_exen = timer2_control_reg_q[ubg_pkg::T2_EXT_EN_BIT];
   wire t1_counter = timer_mode_reg_q[ubg_pkg::T1_COUNTER_BIT];
   wire [1:0] t1_mode_bits = timer_mode_reg_q[ubg_pkg::T1_MODE_LSB +: 2];

   // ----------------------------------------------------------------
   // Timer 1, timer or counter function
   // ----------------------------------------------------------------
   wire t1_step = t1_counter ? pin_fall[0] : 1'b1; // RULE3

   ubg_timer1 u_timer1 (
      .core_clk_in(core_clk_in),
      .reset_n_in(reset_n_in),
      .run_in(timer_mode_reg_q[ubg_pkg::T1_RUN_BIT]),
      .mode_in(ubg_pkg::ubg_t1_mode_t'(t1_mode_bits)),
      .step_in(t1_step),
      .wr_en_in(wr_t1cnt),
      .wr_data_in(hwdata_in[15:0]),
      .count_out(t1_count),
      .ovf_out(t1_ovf)
   );

   // Halves timer 1 overflows unless the rate is doubled
   wire t1_bit_src = t1_ovf & (sel.double_rate | t1_half_q); // RULE2

   // ----------------------------------------------------------------
   // Timer 2, reload, capture and generator use
   // ----------------------------------------------------------------
   wire t2_step = t2_run & (t2_brg ? t2_phase_q : 1'b1); // RULE5 RULE7
   wire t2_wrap = t2_step & (&t2_count_q);
   wire t2_ext_ev = pin_fall[1] & t2_exen;
   // Capture use rolls over to zero, only reload and generator use reload
   wire t2_capmode = t2_cap & ~t2_brg;
   wire t2_reload_ev = t2_wrap & ~t2_capmode; // RULE9

   // Count: software write, then rollover reload, then external reload
   assign t2_count_d = wr_t2cnt ? hwdata_in[15:0] :
      t2_reload_ev ? t2_reload_q : // RULE9
      (t2_ext_ev & ~t2_cap & ~t2_brg) ? t2_reload_q :
      t2_step ? t2_count_q + 16'h0001 : t2_count_q;
   assign t2_reload_d = wr_t2rld ? hwdata_in[15:0] :
      (t2_ext_ev & t2_cap & ~t2_brg) ? t2_count_q : t2_reload_q;

   // Control byte; hardware setting a flag wins over a clearing write
   always_comb begin
      timer2_control_reg_d = wr_t2ctl ? hwdata_in[7:0] : timer2_control_reg_q;
      if (t2_wrap & ~t2_brg) begin
         timer2_control_reg_d[ubg_pkg::T2_OVERFLOW_FLAG_BIT] = 1'b1; // RULE8
      end
      if (t2_ext_ev) begin
         timer2_control_reg_d[ubg_pkg::T2_EXTERNAL_FLAG_BIT] = 1'b1; // RULE8
      end
   end

   // Software registers and timer 2 state
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         timer_mode_reg_q <= ubg_pkg::TIMER_MODE_RST;
         timer2_control_reg_q <= ubg_pkg::T2_CONTROL_RST;
         serial_cfg_q <= ubg_pkg::SERIAL_CFG_RST;
         t2_reload_q <= ubg_pkg::COUNT_RST;
         t2_count_q <= ubg_pkg::COUNT_RST;
      end else begin
         timer2_control_reg_q <= timer2_control_reg_d;
         t2_reload_q <= t2_reload_d;
         t2_count_q <= t2_count_d;
         if (wr_mode) begin
            timer_mode_reg_q <= hwdata_in[7:0];
         end
         if (wr_ser) begin
            serial_cfg_q <= hwdata_in[7:0];
         end
      end
   end

   // Step divider, overflow pulse and timer 1 halving
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         t2_phase_q <= 1'b0;
         t2_ovf_q <= 1'b0;
         t1_half_q <= 1'b0;
      end else begin
         t2_phase_q <= t2_run & t2_brg & ~t2_phase_q;
         t2_ovf_q <= t2_wrap;
         if (t1_ovf) begin
            t1_half_q <= ~t1_half_q;
         end
      end
   end

   // ----------------------------------------------------------------
   // Source choice per direction and bit dividers
   // ----------------------------------------------------------------
   wire tx_src = sel.tx_t2 ? t2_ovf_q : t1_bit_src; // RULE1 RULE11
   wire rx_src = sel.rx_t2 ? t2_ovf_q : t1_bit_src; // RULE1 RULE11

   ubg_bit_div #(.DIV(ubg_pkg::OVF_PER_BIT)) u_tx_div (
      .core_clk_in(core_clk_in),
      .reset_n_in(reset_n_in),
      .src_tick_in(tx_src),
      .tick_out(tx_tick)
   );

   ubg_bit_div #(.DIV(ubg_pkg::OVF_PER_BIT)) u_rx_div (
      .core_clk_in(core_clk_in),
      .reset_n_in(reset_n_in),
      .src_tick_in(rx_src),
      .tick_out(rx_tick)
   );

   assign tx_bit_tick_out = tx_tick.bit_tick;
   assign tx_sample_tick_out = tx_tick.sample_tick;
   assign rx_bit_tick_out = rx_tick.bit_tick;
   assign rx_sample_tick_out = rx_tick.sample_tick;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!reset_n_in);

   sequence s_brg_step;
      t2_step && t2_brg;
   endsequence

   // Leaving generator use may step on the very next cycle
   sequence s_rest;
      !(t2_step && t2_brg);
   endsequence

   t2_no_flag_a: assert property ($rose(timer2_control_reg_q[7]) |-> !$past(t2_brg)) // RULE8
      else $error("overflow flag set in generator use");
   t2_reload_a: assert property ((t2_reload_ev && !wr_t2cnt) |=> t2_count_q == $past(t2_reload_q)) // RULE9
      else $error("timer 2 rollover did not reload");
   t2_half_rate_a: assert property (s_brg_step |=> s_rest) // RULE5
      else $error("timer 2 stepped on back to back cycles");
   t1_halving_a: assert property ((t1_ovf && !sel.double_rate && !t1_half_q) |-> !t1_bit_src) // RULE2
      else $error("timer 1 overflow not halved");
   tx_from_t1_a: assert property ((!sel.tx_t2 && t1_bit_src) |=> tx_sample_tick_out) // RULE11
      else $error("transmit ignored timer 1");
   tx_from_t2_a: assert property ((sel.tx_t2 && t2_ovf_q) |=> tx_sample_tick_out) // RULE6
      else $error("transmit ignored timer 2");
   rx_src_a: assert property (rx_sample_tick_out |->
      ($past(sel.rx_t2) ? $past(t2_ovf_q) : $past(t1_bit_src))) // RULE1
      else $error("receive tick without its source");
   t2_ovf_pulse_a: assert property ((sel.rx_t2 && t2_wrap ##1 sel.rx_t2) |-> // RULE7
      t2_ovf_q ##1 rx_sample_tick_out)
      else $error("timer 2 overflow did not reach receive");

endmodule

//--- src/ubg_bit_div.sv
`timescale 1ns/100ps
module ubg_bit_div #(
   parameter int DIV = ubg_pkg::OVF_PER_BIT
) (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic reset_n_in,
   // Overflow ticks of the chosen timer
   input wire logic src_tick_in,
   // Sample and bit ticks
   output ubg_pkg::ubg_tick_t tick_out
);

   localparam int CW = $clog2(DIV);
   localparam logic [CW-1:0] LAST = CW'(DIV - 1);

   // ----------------------------------------------------------------
   // Parameter check
   // ----------------------------------------------------------------
   if (DIV < 2) begin : g_chk
      $error("ubg_bit_div: DIV must be at least 2");
   end

   logic [CW-1:0] cnt_q;
   logic [CW-1:0] cnt_d;
   ubg_pkg::ubg_tick_t tick_q;
   wire at_last = (cnt_q == LAST);

   // Next count wraps after DIV source ticks
   assign cnt_d = at_last ? '0 : cnt_q + CW'(1);
   assign tick_out = tick_q;

   // Counts source overflows, one bit per DIV of them
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         cnt_q <= '0;
         tick_q <= '0;
      end else begin
         tick_q.sample_tick <= src_tick_in;
         tick_q.bit_tick <= src_tick_in & at_last; // RULE4
         if (src_tick_in) begin
            cnt_q <= cnt_d;
         end
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!reset_n_in);

   bit_after_last_a: assert property ((src_tick_in && at_last) |=> tick_q.bit_tick) // RULE4
      else $error("bit tick missing after last overflow");
   bit_has_cause_a: assert property (tick_q.bit_tick |-> $past(src_tick_in) && cnt_q == '0) // RULE4
      else $error("bit tick without its overflow");

endmodule

//--- src/ubg_pkg.sv
package ubg_pkg;

   // ----------------------------------------------------------------
   // Register map, one aligned 32-bit word each
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_TIMER_MODE = 8'h00;
   localparam logic [7:0] OFS_T2_CONTROL = 8'h04;
   localparam logic [7:0] OFS_T1_COUNT = 8'h08;
   localparam logic [7:0] OFS_T2_RELOAD = 8'h0c;
   localparam logic [7:0] OFS_T2_COUNT = 8'h10;
   localparam logic [7:0] OFS_SERIAL_CFG = 8'h14;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int T1_RUN_BIT = 0;
   localparam int T1_MODE_LSB = 4;
   localparam int T1_COUNTER_BIT = 6;
   localparam int T2_CAPTURE_BIT = 0;
   localparam int T2_RUN_BIT = 2;
   localparam int T2_EXT_EN_BIT = 3;
   localparam int TX_CLOCK_FROM_T2_BIT = 4;
   localparam int RX_CLOCK_FROM_T2_BIT = 5;
   localparam int T2_EXTERNAL_FLAG_BIT = 6;
   localparam int T2_OVERFLOW_FLAG_BIT = 7;
   localparam int DOUBLE_RATE_BIT = 0;

   // ----------------------------------------------------------------
   // Reset values and counts
   // ----------------------------------------------------------------
   localparam logic [7:0] TIMER_MODE_RST = 8'h00;
   localparam logic [7:0] T2_CONTROL_RST = 8'h00;
   localparam logic [7:0] SERIAL_CFG_RST = 8'h00;
   localparam logic [15:0] COUNT_RST = 16'h0000;
   localparam int OVF_PER_BIT = 16;
   localparam int T2_STEP_CYCLES = 2;
   localparam int CORE_CLK_PERIOD_NS = 25;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      T1_M13 = 2'b00,
      T1_M16 = 2'b01,
      T1_MRELOAD = 2'b10,
      T1_MHOLD = 2'b11
   } ubg_t1_mode_t;

   typedef struct packed {
      logic double_rate;
      logic rx_t2;
      logic tx_t2;
   } ubg_sel_t;

   typedef struct packed {
      logic bit_tick;
      logic sample_tick;
   } ubg_tick_t;

endpackage

//--- src/ubg_timer1.sv
`timescale 1ns/100ps
module ubg_timer1 (
   // Clock and reset
   input wire logic core_clk_in,
   input wire logic reset_n_in,
   // Control
   input wire logic run_in,
   input wire ubg_pkg::ubg_t1_mode_t mode_in,
   input wire logic step_in,
   // Software access
   input wire logic wr_en_in,
   input wire logic [15:0] wr_data_in,
   // State
   output logic [15:0] count_out,
   output logic ovf_out
);

   logic [7:0] tl_q;
   logic [7:0] th_q; // timer1_reload_byte in reload mode
   logic ovf_q;
   logic [12:0] n13;
   logic [15:0] n16;
   wire go = run_in & step_in & (mode_in != ubg_pkg::T1_MHOLD);

   // Increment values per width
   assign n13 = {th_q, tl_q[4:0]} + 13'h0001;
   assign n16 = {th_q, tl_q} + 16'h0001;
   assign count_out = {th_q, tl_q};
   assign ovf_out = ovf_q;

   // Counting and rollover per running mode
   always_ff @(posedge core_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         tl_q <= 8'h00;
         th_q <= 8'h00;
         ovf_q <= 1'b0;
      end else if (wr_en_in) begin
         tl_q <= wr_data_in[7:0];
         th_q <= wr_data_in[15:8];
         ovf_q <= 1'b0;
      end else begin
         ovf_q <= 1'b0;
         if (go) begin
            case (mode_in)
               ubg_pkg::T1_M13: begin
                  th_q <= n13[12:5];
                  tl_q[4:0] <= n13[4:0];
                  ovf_q <= &{th_q, tl_q[4:0]};
               end
               ubg_pkg::T1_M16: begin
                  {th_q, tl_q} <= n16;
                  ovf_q <= &{th_q, tl_q};
               end
               ubg_pkg::T1_MRELOAD: begin
                  tl_q <= (&tl_q) ? th_q : tl_q + 8'h01; // RULE10
                  ovf_q <= &tl_q;
               end
               default: begin
                  ovf_q <= 1'b0;
               end
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!reset_n_in);

   wire reload_go = go && mode_in == ubg_pkg::T1_MRELOAD && !wr_en_in;

   reload_keeps_high_a: assert property ((reload_go && &tl_q) |=> // RULE10
      tl_q == $past(th_q) && th_q == $past(th_q) && ovf_q)
      else $error("8-bit reload wrong");
   reload_counts_a: assert property ((reload_go && !(&tl_q)) |=> // RULE3
      tl_q == $past(tl_q) + 8'h01 && !ovf_q)
      else $error("8-bit count did not advance");

endmodule
